/* File: ctrl_model.sv */
// Partner model: modulation and servo ticks and an encoder count.
// Assumes the drive's system clock and its active-low reset.
`timescale 1ns/1ps
module ctrl_model #(
    parameter logic [15:0] VEL_STEP = 16'h0023
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic pwm_tick,
    output logic servo_tick,
    output logic [15:0] enc_count
);
    logic [4:0] pc;
    // A fixed step per servo tick keeps the expected velocity exact
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pc <= 5'h00;
            enc_count <= 16'hFFF0;
        end
        else
        begin
            pc <= pc + 5'h01;
            if (servo_tick)
                enc_count <= enc_count + VEL_STEP;
        end
    end
    assign pwm_tick = (pc[3:0] == 4'hF);
    assign servo_tick = (pc == 5'h1F);
endmodule

/* File: pin_filter.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes raw pins are asynchronous to clk; clean follows only stable levels.
`timescale 1ns/1ps
module pin_filter #(
    parameter int W = 8,
    parameter logic [W-1:0] CLEAN_RST = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    pin_sync_if.filt sig
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } filt_t;

    filt_t st_ff;
    filt_t nxt_st;

    // First stage feeds only the second; agreement is judged on s2 and s3
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = sig.raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.clean = ((st_ff.s2 ~^ st_ff.s3) & st_ff.s3) |
                       ((st_ff.s2 ^ st_ff.s3) & st_ff.clean);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '{CLEAN_RST, CLEAN_RST, CLEAN_RST, CLEAN_RST};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign sig.clean = st_ff.clean;
endmodule

/* File: pin_sync_if.sv */
// Carrier between the top block and its pin filter: raw pins in, clean out.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

/* File: servo_pkg.sv */
// Shared constants of the servo status and clamp block: register map,
// field positions, reset values, fault indices and segment codes.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz system clock.
package servo_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_TEST = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_VEL = 8'h14;
    localparam logic [7:0] OFS_MON = 8'h18;
    localparam logic [7:0] OFS_NONE = 8'hFC;

    localparam int CTRL_W = 11;
    localparam int CTRL_LIM_POS_HI = 0;
    localparam int CTRL_LIM_NEG_HI = 1;
    localparam int CTRL_INH_HI = 2;
    localparam int CTRL_CLR_HI = 3;
    localparam int CTRL_HALL_EN = 4;
    localparam int CTRL_CMD_SEC = 5;
    localparam int CTRL_MON_SEL = 8;
    localparam int CTRL_SOFT_CLR = 16;

    localparam logic [10:0] CTRL_RST = 11'h010;
    localparam logic [15:0] GAIN_RST = 16'h1040;
    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [7:0] DAC_MID = 8'h80;
    localparam int CMD_GAIN_FRAC = 6;
    localparam int TACH_GAIN_FRAC = 4;

    localparam int NUM_PINS = 8;
    localparam int PIN_LIM_POS = 0;
    localparam int PIN_LIM_NEG = 1;
    localparam int PIN_INH = 2;
    localparam int PIN_CLAMP_B = 3;
    localparam int PIN_CLR = 4;
    localparam int PIN_HALL = 5;
    localparam logic [7:0] PIN_RST = 8'h28;

    localparam int NUM_FLT = 9;
    localparam int FLT_HS = 0;
    localparam int FLT_LS = 1;
    localparam int FLT_ENC = 2;
    localparam int FLT_HEAT = 3;
    localparam int FLT_MTEMP = 4;
    localparam int FLT_OVV = 5;
    localparam int FLT_COMM = 6;
    localparam int FLT_HALL = 7;
    localparam int FLT_NVM = 8;

    // Segment order {g,f,e,d,c,b,a}
    localparam logic [6:0] SEG_S = 7'h6D;
    localparam logic [6:0] SEG_L = 7'h38;
    localparam logic [6:0] SEG_E = 7'h79;
    localparam logic [6:0] SEG_H_UP = 7'h76;
    localparam logic [6:0] SEG_H_LO = 7'h74;
    localparam logic [6:0] SEG_B_LO = 7'h7C;
    localparam logic [6:0] SEG_BARS3 = 7'h49;
    localparam logic [6:0] SEG_BARS2 = 7'h09;
    localparam logic [6:0] SEG_ONE = 7'h06;
    localparam logic [6:0] SEG_C_UP = 7'h39;
    localparam logic [6:0] SEG_C_LO = 7'h58;
    localparam logic [6:0] SEG_F = 7'h71;
    localparam logic [6:0] SEG_O = 7'h3F;
    localparam logic [6:0] SEG_8 = 7'h7F;
    localparam logic [6:0] FLT_SEG [NUM_FLT] = '{SEG_S, SEG_L, SEG_E,
        SEG_H_UP, SEG_H_LO, SEG_B_LO, SEG_BARS3, SEG_BARS2, SEG_ONE};

    typedef enum logic [2:0] {
        MON_TEST = 3'b000,
        MON_CMD = 3'b001,
        MON_ABS_CUR = 3'b010,
        MON_VEL_RAW = 3'b011,
        MON_VEL_SCL = 3'b100,
        MON_CUR_CMD = 3'b101,
        MON_R_PHASE = 3'b110,
        MON_S_PHASE = 3'b111
    } mon_sel_t;
endpackage

/* File: servo_status.sv */
// Status indicator, clamp, alarm, command gain and monitor logic of a drive.
// Assumes an AHB-Lite master, same-clock fault and loop inputs, async pins.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - Decimal point stays lit whenever the logic runs.
// - With Hall sensors and normal running, one outer segment lights.
// - Without Hall sensors all six outer segments light, a zero.
// - Clamp or fault replaces the Hall pattern with a character.
// - Fault characters S, L, E, H, h, b for the six listed faults.
// - Three bars for commutation failure, top and bottom for bad Hall.
// - Character 1 for a failed parameter checksum.
// - Characters C, c, F, O and 8 for the listed states.
// - Twelve-bit command input with primary and secondary channels.
// - Signed gain on the command; negative gain inverts it.
// - Monitor is an 8-bit, 256-step bipolar code.
// - Monitor source selects one of eight signals.
// - Raw velocity is count change per servo tick; scaled velocity applies tach gain.
// - Monitor code updates once per modulation cycle.
// - Monitor is suspended while parameters are saved or recalled.
// - Monitor value need only be defined after reset completes.
// - Each travel-stop input has a selectable asserted level.
// - Travel stops block current of their own direction.
// - Inhibit disables the output stage and shows the clamp character.
// - Inhibit asserted level is configurable.
// - Alarm output is low while any fault is present.
// - Faults latch and disable until a clear arrives.
// - Clear input polarity is configurable; all segments light while held.
module servo_status #(
    parameter int ADC_W = 12,
    parameter int DAC_W = 8
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic LIM_POS,
    input wire logic LIM_NEG,
    input wire logic INHIBIT,
    input wire logic CLAMP_IN_B,
    input wire logic CLEAR_IN,
    input wire logic [2:0] HALL,
    input wire logic [servo_pkg::NUM_FLT-1:0] FAULT_EVT,
    input wire logic FOLDBACK,
    input wire logic NV_BUSY,
    input wire logic PWM_TICK,
    input wire logic SERVO_TICK,
    input wire logic [15:0] ENC_COUNT,
    input wire logic ADC_VALID,
    input wire logic [ADC_W-1:0] ADC_PRI,
    input wire logic [ADC_W-1:0] ADC_SEC,
    input wire logic [11:0] CUR_ACT,
    input wire logic [11:0] CUR_CMD,
    input wire logic [11:0] CUR_R,
    input wire logic [11:0] CUR_S,
    output logic [6:0] SEG,
    output logic SEG_DP,
    output logic FAULT_B,
    output logic STAGE_EN,
    output logic POS_CUR_BLOCK,
    output logic NEG_CUR_BLOCK,
    output logic [15:0] CMD_ADJ,
    output logic [DAC_W-1:0] DAC_CODE,
    output logic DAC_EN
);
    typedef struct packed {
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic [servo_pkg::CTRL_W-1:0] ctrl;
        logic [15:0] gain;
        logic [7:0] test;
        logic soft_clr;
        logic [servo_pkg::NUM_FLT-1:0] fault;
        logic dp;
        logic [6:0] seg;
        logic fault_b;
        logic stage_en;
        logic pos_blk;
        logic neg_blk;
        logic [15:0] cmd_adj;
        logic [15:0] enc_prev;
        logic [15:0] vel_raw;
        logic [15:0] vel_scl;
        logic [DAC_W-1:0] dac;
        logic dac_en;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic [servo_pkg::NUM_PINS-1:0] pins;
    logic lim_pos_act;
    logic lim_neg_act;
    logic inh_act;
    logic clamp_act;
    logic in_reset;
    logic clr;
    logic hall_en;
    logic [2:0] hall;
    logic hall_bad;
    logic [servo_pkg::NUM_FLT-1:0] flt_evt;

    pin_sync_if #(.W(servo_pkg::NUM_PINS)) pins_if ();

    assign pins_if.raw = {HALL, CLEAR_IN, CLAMP_IN_B, INHIBIT, LIM_NEG,
                          LIM_POS};

    pin_filter #(
        .W(servo_pkg::NUM_PINS),
        .CLEAN_RST(servo_pkg::PIN_RST)
    ) u_pins (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .sig(pins_if)
    );

    assign pins = pins_if.clean;
    assign lim_pos_act = pins[servo_pkg::PIN_LIM_POS] ~^
                         st_ff.ctrl[servo_pkg::CTRL_LIM_POS_HI];
    assign lim_neg_act = pins[servo_pkg::PIN_LIM_NEG] ~^
                         st_ff.ctrl[servo_pkg::CTRL_LIM_NEG_HI];
    assign inh_act = pins[servo_pkg::PIN_INH] ~^
                     st_ff.ctrl[servo_pkg::CTRL_INH_HI];
    assign clamp_act = !pins[servo_pkg::PIN_CLAMP_B];
    assign in_reset = pins[servo_pkg::PIN_CLR] ~^
                      st_ff.ctrl[servo_pkg::CTRL_CLR_HI];
    assign clr = in_reset | st_ff.soft_clr;
    assign hall_en = st_ff.ctrl[servo_pkg::CTRL_HALL_EN];
    assign hall = pins[servo_pkg::PIN_HALL +: 3];
    assign hall_bad = hall_en && (hall == 3'h0 || hall == 3'h7);
    assign flt_evt = FAULT_EVT |
        ({{(servo_pkg::NUM_FLT-1){1'b0}}, hall_bad} << servo_pkg::FLT_HALL);

    // Top eight bits of a 12-bit signed value, offset binary for the DAC
    function automatic logic [7:0] to_dac(input logic [11:0] v);
        to_dac = {~v[11], v[10:4]};
    endfunction

    always_comb
    begin
        logic [6:0] fseg;
        logic signed [19:0] cprod;
        logic signed [23:0] vprod;
        logic [ADC_W-1:0] adc_sel;
        logic [11:0] mon12;
        logic [11:0] cur_abs;
        logic take;
        fseg = 7'h00;
        cprod = 20'h00000;
        vprod = 24'h000000;
        adc_sel = '0;
        mon12 = 12'h000;
        cur_abs = 12'h000;
        take = HSEL && HREADY && HTRANS[1];
        nxt_st = st_ff;
        nxt_st.soft_clr = 1'b0;

        if (st_ff.dp_valid && st_ff.dp_write)
        begin
            if (st_ff.dp_addr == servo_pkg::OFS_CTRL)
            begin
                nxt_st.ctrl = HWDATA[servo_pkg::CTRL_W-1:0];
                nxt_st.soft_clr = HWDATA[servo_pkg::CTRL_SOFT_CLR];
            end
            else if (st_ff.dp_addr == servo_pkg::OFS_GAIN)
            begin
                nxt_st.gain = HWDATA[15:0];
            end
            else if (st_ff.dp_addr == servo_pkg::OFS_TEST)
            begin
                nxt_st.test = HWDATA[7:0];
            end
        end

        // Latched faults; a new event wins over a clear in the same cycle
        nxt_st.fault = (st_ff.fault & ~{servo_pkg::NUM_FLT{clr}}) |
                       flt_evt;
        nxt_st.fault_b = ~|nxt_st.fault;
        nxt_st.stage_en = nxt_st.fault_b && !inh_act && !clamp_act &&
                          !in_reset;
        nxt_st.pos_blk = lim_pos_act;
        nxt_st.neg_blk = lim_neg_act;
        nxt_st.dp = 1'b1;

        for (int i = servo_pkg::NUM_FLT - 1; i >= 0; i--)
        begin
            if (nxt_st.fault[i])
            begin
                fseg = servo_pkg::FLT_SEG[i];
            end
        end

        if (in_reset)
        begin
            nxt_st.seg = servo_pkg::SEG_8;
        end
        else if (!nxt_st.fault_b)
        begin
            nxt_st.seg = fseg;
        end
        else if (inh_act)
        begin
            nxt_st.seg = servo_pkg::SEG_C_UP;
        end
        else if (clamp_act)
        begin
            nxt_st.seg = servo_pkg::SEG_C_LO;
        end
        else if (FOLDBACK)
        begin
            nxt_st.seg = servo_pkg::SEG_F;
        end
        else if (hall_en)
        begin
            case (hall)
                3'b001: nxt_st.seg = 7'h01;
                3'b011: nxt_st.seg = 7'h02;
                3'b010: nxt_st.seg = 7'h04;
                3'b110: nxt_st.seg = 7'h08;
                3'b100: nxt_st.seg = 7'h10;
                3'b101: nxt_st.seg = 7'h20;
                default: nxt_st.seg = 7'h00;
            endcase
        end
        else
        begin
            nxt_st.seg = servo_pkg::SEG_O;
        end

        // Command path
        adc_sel = st_ff.ctrl[servo_pkg::CTRL_CMD_SEC] ? ADC_SEC :
                  ADC_PRI;
        cprod = $signed(adc_sel) * $signed(st_ff.gain[7:0]);
        if (ADC_VALID)
        begin
            nxt_st.cmd_adj = 16'(cprod >>> servo_pkg::CMD_GAIN_FRAC);
        end

        if (SERVO_TICK)
        begin
            nxt_st.vel_raw = ENC_COUNT - st_ff.enc_prev;
            nxt_st.enc_prev = ENC_COUNT;
        end
        vprod = $signed(nxt_st.vel_raw) * $signed(st_ff.gain[15:8]);
        nxt_st.vel_scl = 16'(vprod >>> servo_pkg::TACH_GAIN_FRAC);

        cur_abs = CUR_ACT[11] ? 12'(-CUR_ACT) : CUR_ACT;
        if (CUR_ACT == 12'h800)
        begin
            cur_abs = 12'h7FF;
        end

        case (servo_pkg::mon_sel_t'(st_ff.ctrl[servo_pkg::CTRL_MON_SEL +: 3]))
            servo_pkg::MON_TEST: mon12 = {st_ff.test, 4'h0};
            servo_pkg::MON_CMD: mon12 = st_ff.cmd_adj[11:0];
            servo_pkg::MON_ABS_CUR: mon12 = cur_abs;
            servo_pkg::MON_VEL_RAW: mon12 = st_ff.vel_raw[11:0];
            servo_pkg::MON_VEL_SCL: mon12 = st_ff.vel_scl[11:0];
            servo_pkg::MON_CUR_CMD: mon12 = CUR_CMD;
            servo_pkg::MON_R_PHASE: mon12 = CUR_R;
            servo_pkg::MON_S_PHASE: mon12 = CUR_S;
            default: mon12 = 12'h000;
        endcase

        // Frozen during parameter storage so the output shows no garbage
        nxt_st.dac_en = !NV_BUSY;
        if (PWM_TICK && !NV_BUSY)
        begin
            nxt_st.dac = to_dac(mon12);
        end

        // Address phase; read data reflects writes landing at the same edge
        nxt_st.dp_valid = take;
        nxt_st.hrdata = 32'h0000_0000;
        if (take)
        begin
            nxt_st.dp_write = HWRITE;
            nxt_st.dp_addr = (HADDR[31:8] == 24'h000000) ? HADDR[7:0] :
                             servo_pkg::OFS_NONE;
            if (!HWRITE)
            begin
                if (nxt_st.dp_addr == servo_pkg::OFS_CTRL)
                begin
                    nxt_st.hrdata = {21'h000000, nxt_st.ctrl};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_GAIN)
                begin
                    nxt_st.hrdata = {16'h0000, nxt_st.gain};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_TEST)
                begin
                    nxt_st.hrdata = {24'h000000, nxt_st.test};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_STATUS)
                begin
                    nxt_st.hrdata = {9'h000, nxt_st.seg, 1'b0, in_reset,
                        clamp_act, inh_act, nxt_st.neg_blk, nxt_st.pos_blk,
                        nxt_st.stage_en, nxt_st.fault};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_CMD)
                begin
                    nxt_st.hrdata = {16'h0000, nxt_st.cmd_adj};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_VEL)
                begin
                    nxt_st.hrdata = {nxt_st.vel_scl, nxt_st.vel_raw};
                end
                else if (nxt_st.dp_addr == servo_pkg::OFS_MON)
                begin
                    nxt_st.hrdata = {23'h000000, nxt_st.dac_en, nxt_st.dac};
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_ff <= '{ctrl: servo_pkg::CTRL_RST, gain: servo_pkg::GAIN_RST,
                       test: servo_pkg::TEST_RST, dp: 1'b1,
                       seg: servo_pkg::SEG_8, fault_b: 1'b1,
                       dac: servo_pkg::DAC_MID, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign HRDATA = st_ff.hrdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign SEG = st_ff.seg;
    assign SEG_DP = st_ff.dp;
    assign FAULT_B = st_ff.fault_b;
    assign STAGE_EN = st_ff.stage_en;
    assign POS_CUR_BLOCK = st_ff.pos_blk;
    assign NEG_CUR_BLOCK = st_ff.neg_blk;
    assign CMD_ADJ = st_ff.cmd_adj;
    assign DAC_CODE = st_ff.dac;
    assign DAC_EN = st_ff.dac_en;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    dp_lit_a: assert property (SEG_DP)
        else $error("decimal point dark");
    alarm_low_a: assert property (|flt_evt |=> !FAULT_B && !STAGE_EN)
        else $error("alarm not raised on fault");
    fault_hold_a: assert property (!FAULT_B && !clr |=> !FAULT_B)
        else $error("fault dropped without clear");
    stage_off_a: assert property (inh_act |=> !STAGE_EN)
        else $error("stage on under inhibit");
    pos_block_a: assert property (lim_pos_act |=> POS_CUR_BLOCK)
        else $error("positive current not blocked");
    neg_block_a: assert property (lim_neg_act |=> NEG_CUR_BLOCK)
        else $error("negative current not blocked");
    hall_ring_a: assert property (!in_reset && FAULT_B && !(|flt_evt) &&
        !inh_act && !clamp_act && !FOLDBACK && hall_en
        |=> $onehot(SEG))
        else $error("hall ring not one segment");
    zero_ring_a: assert property (!in_reset && FAULT_B && !(|flt_evt) &&
        !inh_act && !clamp_act && !FOLDBACK && !hall_en
        |=> SEG == servo_pkg::SEG_O)
        else $error("zero not shown without halls");
    clear_show_a: assert property (in_reset |=> SEG == servo_pkg::SEG_8)
        else $error("eight not shown in reset");
    hs_char_a: assert property (FAULT_EVT[servo_pkg::FLT_HS] && !in_reset
        |=> SEG == servo_pkg::SEG_S)
        else $error("breaker trip character wrong");
    inh_char_a: assert property (inh_act && !in_reset && FAULT_B &&
        !(|flt_evt) |=> SEG == servo_pkg::SEG_C_UP)
        else $error("clamp character missing");
    dac_hold_a: assert property (!PWM_TICK |=> $stable(DAC_CODE))
        else $error("monitor changed between ticks");
    nv_quiet_a: assert property (NV_BUSY |=> !DAC_EN && $stable(DAC_CODE))
        else $error("monitor active during storage");
endmodule

/* File: servo_status_and_clamp_logic_test.sv */
// Self-checking bench of the servo status and clamp block.
// Assumes the controller model for ticks and encoder; bus tasks here.
`timescale 1ns/1ps
module servo_status_and_clamp_logic_test;
    logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, rd_dp;
    logic lim_pos, lim_neg, inhibit, clamp_b, clear_in, foldback, nv_busy;
    logic adc_valid, pwm_tick, servo_tick, seg_dp, fault_b, stage_en;
    logic pos_blk, neg_blk, dac_en;
    logic [31:0] haddr, hwdata, hrdata, ctrl;
    logic [31:0] exp_q [$];
    logic [1:0] htrans;
    logic [2:0] hsize, hall;
    logic [8:0] fevt;
    logic [15:0] enc_count, cmd_adj, cmd_exp, vs;
    logic [11:0] adc_pri, adc_sec, cur_act, cur_cmd, cur_r, cur_s, src;
    logic [6:0] seg;
    logic [7:0] dac_code, g, t, tv, dc;
    logic signed [19:0] p;
    logic signed [23:0] v;
    logic [2:0] hv [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int fails = 0;
    int checks = 0;

    servo_status dut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .LIM_POS(lim_pos), .LIM_NEG(lim_neg),
        .INHIBIT(inhibit), .CLAMP_IN_B(clamp_b), .CLEAR_IN(clear_in),
        .HALL(hall), .FAULT_EVT(fevt), .FOLDBACK(foldback),
        .NV_BUSY(nv_busy), .PWM_TICK(pwm_tick), .SERVO_TICK(servo_tick),
        .ENC_COUNT(enc_count), .ADC_VALID(adc_valid), .ADC_PRI(adc_pri),
        .ADC_SEC(adc_sec), .CUR_ACT(cur_act), .CUR_CMD(cur_cmd),
        .CUR_R(cur_r), .CUR_S(cur_s), .SEG(seg), .SEG_DP(seg_dp),
        .FAULT_B(fault_b), .STAGE_EN(stage_en), .POS_CUR_BLOCK(pos_blk),
        .NEG_CUR_BLOCK(neg_blk), .CMD_ADJ(cmd_adj), .DAC_CODE(dac_code),
        .DAC_EN(dac_en)
    );
    ctrl_model ctl (.clk(clk_sys), .rst_b(rst_b), .pwm_tick(pwm_tick),
        .servo_tick(servo_tick), .enc_count(enc_count));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One single word transfer; a read notes its expected word in the queue
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= 2'h2;
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
    endtask

    task automatic setc(input logic [31:0] c);
        ctrl = c;
        bus(8'h00, 1'b1, c);
    endtask

    task automatic clr();
        bus(8'h00, 1'b1, ctrl | 32'h00010000);
        cyc(2);
        check(fault_b, 1'b1);
    endtask

    task automatic tick();
        @(posedge clk_sys iff pwm_tick === 1'b1);
        cyc(2);
    endtask

    // Absolute current is driven at its most negative value to hit the clip
    function automatic logic [7:0] mon(input int m);
        logic [11:0] s;
        case (m)
            0: s = {tv, 4'h0};
            1: s = cmd_exp[11:0];
            2: s = 12'h7FF;
            3: s = 12'h023;
            4: s = vs[11:0];
            5: s = cur_cmd;
            6: s = cur_r;
            default: s = cur_s;
        endcase
        return {~s[11], s[10:4]};
    endfunction

    task automatic tally_and_finish();
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        if (rd_dp === 1'b1 && hreadyout === 1'b1)
            check(hrdata, exp_q.pop_front());
        if (hreadyout === 1'b1)
            rd_dp <= htrans[1] & ~hwrite & hsel;
    end

    // Far beyond the few hundred cycles that the sequence needs
    initial
    begin
        #500000;
        fails++;
        tally_and_finish();
    end

    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, fevt, rd_dp} = '0;
        {foldback, nv_busy, adc_valid, adc_pri, adc_sec} = '0;
        {cur_act, cur_cmd, cur_r, cur_s} = '0;
        {lim_pos, lim_neg, inhibit, clamp_b, clear_in} = 5'h1F;
        hsize = 3'h2;
        hall = 3'h1;
        rst_b = 1'b0;
        ctrl = 32'h00000010;
        void'($urandom(32'h6745));
        cyc(2);
        check({seg_dp, seg, dac_code}, 16'hFF80);
        cyc(2);
        rst_b <= 1'b1;
        cyc(10);
        bus(8'h00, 1'b0, 32'h00000010);
        bus(8'hFC, 1'b1, 32'hFFFFFFFF);
        bus(8'hFC, 1'b0, 32'h00000000);
        for (int i = 0; i < 6; i++)
        begin
            hall <= hv[i];
            cyc(8);
            check(seg, 7'h01 << i);
        end
        check({fault_b, stage_en, pos_blk, neg_blk}, 4'hC);
        hall <= 3'h0;
        cyc(8);
        check({fault_b, seg}, 8'h09);
        hall <= 3'h1;
        cyc(8);
        check(seg, 7'h09);
        clr();
        for (int i = 0; i < 10; i++)
        begin
            fevt <= (i < 9) ? 9'h001 << i : 9'h120;
            cyc(1);
            fevt <= 9'h000;
            cyc(2);
            check(seg,
                (i < 9) ? servo_pkg::FLT_SEG[i] : 7'h7C);
            check({fault_b, stage_en}, 2'h0);
            clr();
        end
        foldback <= 1'b1;
        cyc(2);
        check(seg, 7'h71);
        foldback <= 1'b0;
        clamp_b <= 1'b0;
        cyc(8);
        check(seg, 7'h58);
        clamp_b <= 1'b1;
        inhibit <= 1'b0;
        cyc(8);
        check({stage_en, seg}, 8'h39);
        setc(ctrl | 32'h00000004);
        cyc(2);
        check({stage_en, seg}, 8'h81);
        inhibit <= 1'b1;
        cyc(8);
        check({stage_en, seg}, 8'h39);
        inhibit <= 1'b0;
        setc(ctrl & ~32'h00000010);
        cyc(8);
        check(seg, 7'h3F);
        fevt <= 9'h004;
        cyc(1);
        fevt <= 9'h000;
        clear_in <= 1'b0;
        cyc(8);
        check({fault_b, stage_en, seg}, 9'h17F);
        clear_in <= 1'b1;
        cyc(8);
        check({fault_b, stage_en, seg}, 9'h1BF);
        setc(ctrl | 32'h00000008);
        cyc(2);
        check(seg, 7'h7F);
        clear_in <= 1'b0;
        lim_pos <= 1'b0;
        lim_neg <= 1'b0;
        cyc(8);
        check({pos_blk, neg_blk, seg}, 9'h1BF);
        setc(ctrl | 32'h00000003);
        cyc(2);
        check({pos_blk, neg_blk}, 2'h0);
        lim_neg <= 1'b1;
        cyc(8);
        check({pos_blk, neg_blk}, 2'h1);
        for (int k = 0; k < 4; k++)
        begin
            g = (k == 0) ? 8'hC0 : 8'($urandom);
            t = 8'($urandom);
            adc_pri <= 12'($urandom);
            adc_sec <= 12'($urandom);
            setc({ctrl[31:6], k[0], ctrl[4:0]});
            bus(8'h04, 1'b1, {16'h0000, t, g});
            adc_valid <= 1'b1;
            cyc(1);
            adc_valid <= 1'b0;
            cyc(2);
            src = k[0] ? adc_sec : adc_pri;
            p = $signed(src) * $signed(g);
            p = p >>> 6;
            cmd_exp = p[15:0];
            check(cmd_adj, cmd_exp);
            bus(8'h10, 1'b0, {16'h0000, cmd_exp});
        end
        v = $signed(16'h0023) * $signed(t);
        v = v >>> 4;
        vs = v[15:0];
        cur_act <= 12'h800;
        cur_cmd <= 12'($urandom);
        cur_r <= 12'($urandom);
        cur_s <= 12'($urandom);
        tv = 8'($urandom);
        bus(8'h08, 1'b1, {24'h000000, tv});
        repeat (3) @(posedge clk_sys iff servo_tick === 1'b1);
        for (int m = 0; m < 8; m++)
        begin
            setc({ctrl[31:11], 3'(m), ctrl[7:0]});
            tick();
            check({dac_en, dac_code},
                {1'b1, mon(m)});
        end
        dc = mon(7);
        cur_s <= ~cur_s;
        cyc(3);
        check(dac_code, dc);
        tick();
        check(dac_code, mon(7));
        dc = mon(7);
        nv_busy <= 1'b1;
        cur_s <= ~cur_s;
        tick();
        check({dac_en, dac_code}, {1'b0, dc});
        nv_busy <= 1'b0;
        tick();
        check({dac_en, dac_code}, {1'b1, mon(7)});
        tally_and_finish();
    end
endmodule
